// ### design/rmds_top.sv
// Purpose: bit separation, rate matching, multiplexing, mark insertion, segmentation
// Assumes: channel frames arrive in channel order, first and last bit flagged
// Notes:   input is taken at most every second cycle, output has one register
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "rmds_map.svh"
module rmds_top (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [6:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  input  wire logic        inValid,
  output logic             inReady,
  input  wire logic        inBit,
  input  wire logic        inFirst,
  input  wire logic        inLast,
  input  wire logic [1:0]  inChan,
  output logic             outValid,
  input  wire logic        outReady,
  output logic             outBit,
  output logic             outDtx,
  output logic             outFirst,
  output logic      [2:0]  outPhys,
  output logic             frameDone
);
  rmds_pkg::rmds_top_t  cur;
  rmds_pkg::rmds_top_t  next_cur;
  rmds_pkg::rmds_chan_t cfgSel;
  rmds_pkg::rmds_chan_t chanRd;
  rmds_pkg::rmds_bit_t  typeNow;
  logic                 take;
  logic                 repEmit;
  logic [1:0]           selChan;
  logic                 dl;
  logic                 flex;
  logic                 turbo;
  logic                 bypass;
  logic                 punct;
  logic                 lastCh;
  logic                 revOrder;
  logic [2:0]           nph;
  logic [18:0]          padTarget;
  logic [18:0]          fillTarget;
  logic                 drop;
  logic                 repPend;
  logic                 doEmit;
  logic                 emitBit;
  logic                 emitDtx;
  logic                 tailCheck;

  rmds_rm_if rmA ();
  rmds_rm_if rmB ();

  rmds_rate_engine u_engPar1 (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .rm       (rmA)
  );

  rmds_rate_engine u_engPar2 (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .rm       (rmB)
  );

  // type of the first bit of a channel frame
  function automatic rmds_pkg::rmds_bit_t startType(
    input logic [1:0] transmission_interval,
    input logic [2:0] fidx,
    input logic       down
  );
    rmds_pkg::rmds_bit_t t;
    t = rmds_pkg::BIT_SYS;
    if (!down) begin
      case (transmission_interval)
        2'h1: t = fidx[0] ? rmds_pkg::BIT_PAR1 : rmds_pkg::BIT_SYS;
        2'h2: begin
          case (fidx[1:0])
            2'h1:    t = rmds_pkg::BIT_PAR2;
            2'h2:    t = rmds_pkg::BIT_PAR1;
            default: t = rmds_pkg::BIT_SYS;
          endcase
        end
        2'h3: begin
          case (fidx)
            3'h1, 3'h4, 3'h7: t = rmds_pkg::BIT_PAR1;
            3'h2, 3'h5:       t = rmds_pkg::BIT_PAR2;
            default:          t = rmds_pkg::BIT_SYS;
          endcase
        end
        default: t = rmds_pkg::BIT_SYS;
      endcase
    end
    return t;
  endfunction : startType

  // cyclic successor, forward S,P1,P2 or reverse S,P2,P1
  function automatic rmds_pkg::rmds_bit_t nextType(
    input rmds_pkg::rmds_bit_t t,
    input logic                rev
  );
    rmds_pkg::rmds_bit_t r;
    r = rmds_pkg::BIT_SYS;
    case (t)
      rmds_pkg::BIT_SYS:  r = rev ? rmds_pkg::BIT_PAR2 : rmds_pkg::BIT_PAR1;
      rmds_pkg::BIT_PAR1: r = rev ? rmds_pkg::BIT_SYS : rmds_pkg::BIT_PAR2;
      default:            r = rev ? rmds_pkg::BIT_PAR1 : rmds_pkg::BIT_SYS;
    endcase
    return r;
  endfunction : nextType

  always_comb begin : decode
    take     = inValid && cur.inReady;
    repEmit  = (cur.state == rmds_pkg::ST_REP) && (!cur.outValid || outReady);
    selChan  = take ? inChan : cur.chan;
    cfgSel   = cur.ch[selChan];
    chanRd   = cur.ch[regAddr[5:4]];
    dl       = cur.ctrl[`RMDS_CTRL_DL];
    flex     = cur.ctrl[`RMDS_CTRL_FLEX];
    nph      = cur.ctrl[`RMDS_CTRL_NPH_LO +: 3];
    turbo    = cfgSel.cfg[`RMDS_CFG_TURBO];
    bypass   = (cfgSel.adj == 16'h0000);
    punct    = cfgSel.adj[15];
    lastCh   = (selChan == cur.ctrl[`RMDS_CTRL_NCH_LO +: 2]);
    revOrder = !dl && cfgSel.cfg[`RMDS_CFG_TTI_LO];

    // bit type of the element being taken
    if (take && inFirst) begin
      typeNow = startType(cfgSel.cfg[`RMDS_CFG_TTI_LO +: 2],
                          cfgSel.cfg[`RMDS_CFG_FIDX_LO +: 3], dl);
    end else begin
      typeNow = cur.nextType;
    end

    // mark targets of the channel tail and of the composite frame
    padTarget  = {3'h0, cfgSel.res} << cfgSel.cfg[`RMDS_CFG_TTI_LO +: 2];
    fillTarget = {3'h0, cur.phyLen} * ({16'h0000, nph} + 19'h00001);

    // engine A: non-turbo bits, turbo repeat and turbo first parity
    rmA.load     = take && inFirst;
    rmA.puncture = punct;
    rmA.eIni     = cfgSel.eIni1;
    rmA.ePlus    = cfgSel.ePlus1;
    rmA.eMinus   = cfgSel.eMinus1;
    // systematic bits bypass both engines while puncturing turbo data
    rmA.take     = take && !bypass &&
                   (!punct || !turbo || (typeNow == rmds_pkg::BIT_PAR1));
    rmA.again    = repEmit;

    // engine B: second parity of punctured turbo data
    rmB.load     = take && inFirst;
    rmB.puncture = 1'b1;
    rmB.eIni     = cfgSel.eIni2;
    rmB.ePlus    = cfgSel.ePlus2;
    rmB.eMinus   = cfgSel.eMinus2;
    rmB.take     = take && !bypass && punct && turbo &&
                   (typeNow == rmds_pkg::BIT_PAR2);
    rmB.again    = 1'b0;

    drop    = (rmA.take && punct && rmA.hitTake) || (rmB.take && rmB.hitTake);
    repPend = rmA.take && !punct && rmA.hitTake;
  end

  always_comb begin : step
    next_cur           = cur;
    next_cur.frameDone = 1'b0;
    next_cur.rdata     = 16'h0000;
    doEmit             = 1'b0;
    emitBit            = 1'b0;
    emitDtx            = 1'b0;
    tailCheck          = 1'b0;
    if (cur.outValid && outReady) begin
      next_cur.outValid = 1'b0;
    end

    // register writes take effect on the next edge
    if (regWr) begin
      if (regAddr == `RMDS_REG_CTRL) begin
        next_cur.ctrl = regWdata;
      end else if (regAddr == `RMDS_REG_PHYLEN) begin
        next_cur.phyLen = regWdata;
      end else if (regAddr[`RMDS_CH_SPACE]) begin
        if (regAddr[3:0] == `RMDS_F_CFG) begin
          next_cur.ch[regAddr[5:4]].cfg = regWdata;
        end else if (regAddr[3:0] == `RMDS_F_ADJ) begin
          next_cur.ch[regAddr[5:4]].adj = regWdata;
        end else if (regAddr[3:0] == `RMDS_F_EINI1) begin
          next_cur.ch[regAddr[5:4]].eIni1 = regWdata;
        end else if (regAddr[3:0] == `RMDS_F_EPLUS1) begin
          next_cur.ch[regAddr[5:4]].ePlus1 = regWdata;
        end else if (regAddr[3:0] == `RMDS_F_EMINUS1) begin
          next_cur.ch[regAddr[5:4]].eMinus1 = regWdata;
        end else if (regAddr[3:0] == `RMDS_F_EINI2) begin
          next_cur.ch[regAddr[5:4]].eIni2 = regWdata;
        end else if (regAddr[3:0] == `RMDS_F_EPLUS2) begin
          next_cur.ch[regAddr[5:4]].ePlus2 = regWdata;
        end else if (regAddr[3:0] == `RMDS_F_EMINUS2) begin
          next_cur.ch[regAddr[5:4]].eMinus2 = regWdata;
        end else if (regAddr[3:0] == `RMDS_F_RES) begin
          next_cur.ch[regAddr[5:4]].res = regWdata;
        end
      end
    end

    // read answer stands for one cycle, zero otherwise
    if (regRd) begin
      if (regAddr == `RMDS_REG_CTRL) begin
        next_cur.rdata = cur.ctrl;
      end else if (regAddr == `RMDS_REG_PHYLEN) begin
        next_cur.rdata = cur.phyLen;
      end else if (regAddr == `RMDS_REG_STATUS) begin
        next_cur.rdata = {13'h0000, !cur.firstPend, cur.state};
      end else if (regAddr == `RMDS_REG_CHCOUNT) begin
        next_cur.rdata = cur.chanCnt;
      end else if (regAddr == `RMDS_REG_TOTAL) begin
        next_cur.rdata = cur.lastTotal;
      end else if (regAddr[`RMDS_CH_SPACE]) begin
        if (regAddr[3:0] == `RMDS_F_CFG) begin
          next_cur.rdata = chanRd.cfg;
        end else if (regAddr[3:0] == `RMDS_F_ADJ) begin
          next_cur.rdata = chanRd.adj;
        end else if (regAddr[3:0] == `RMDS_F_EINI1) begin
          next_cur.rdata = chanRd.eIni1;
        end else if (regAddr[3:0] == `RMDS_F_EPLUS1) begin
          next_cur.rdata = chanRd.ePlus1;
        end else if (regAddr[3:0] == `RMDS_F_EMINUS1) begin
          next_cur.rdata = chanRd.eMinus1;
        end else if (regAddr[3:0] == `RMDS_F_EINI2) begin
          next_cur.rdata = chanRd.eIni2;
        end else if (regAddr[3:0] == `RMDS_F_EPLUS2) begin
          next_cur.rdata = chanRd.ePlus2;
        end else if (regAddr[3:0] == `RMDS_F_EMINUS2) begin
          next_cur.rdata = chanRd.eMinus2;
        end else if (regAddr[3:0] == `RMDS_F_RES) begin
          next_cur.rdata = chanRd.res;
        end
      end
    end

    // one element register: a new element only once the old one has left
    case (cur.state)
      rmds_pkg::ST_TAKE: begin
        if (take) begin
          next_cur.chan     = inChan;
          next_cur.curBit   = inBit;
          next_cur.lastIn   = inLast;
          next_cur.nextType = nextType(typeNow, revOrder);
          if (inFirst) begin
            next_cur.chanCnt = 16'h0000;
          end
          if (!drop) begin
            doEmit  = 1'b1;
            emitBit = inBit;
          end
          if (repPend) begin
            next_cur.state = rmds_pkg::ST_REP;
          end else begin
            tailCheck = inLast;
          end
        end
      end
      // emit copies while the accumulator stays at or below zero
      rmds_pkg::ST_REP: begin
        if (repEmit) begin
          doEmit  = 1'b1;
          emitBit = cur.curBit;
          if (!rmA.hitAgain) begin
            next_cur.state = rmds_pkg::ST_TAKE;
            tailCheck      = cur.lastIn;
          end
        end
      end
      // pad and fill states emit marks only, never data
      default: begin
        if (!next_cur.outValid) begin
          doEmit    = 1'b1;
          emitDtx   = 1'b1;
          tailCheck = 1'b1;
        end
      end
    endcase

    if (doEmit) begin
      next_cur.outValid  = 1'b1;
      next_cur.outBit    = emitBit && !emitDtx;
      next_cur.outDtx    = emitDtx;
      next_cur.outFirst  = cur.firstPend;
      next_cur.firstPend = 1'b0;
      next_cur.outPhys   = cur.physIdx;
      next_cur.chanCnt   = next_cur.chanCnt + 16'h0001;
      next_cur.total     = cur.total + 16'h0001;
      if ((cur.physCnt + 16'h0001) >= cur.phyLen) begin
        next_cur.physCnt = 16'h0000;
        next_cur.physIdx = (cur.physIdx == nph) ? 3'h0 : cur.physIdx + 3'h1;
      end else begin
        next_cur.physCnt = cur.physCnt + 16'h0001;
      end
    end

    // channel tail: pad, fill or close the composite frame
    if (tailCheck) begin
      if (dl && !flex && ({3'h0, next_cur.chanCnt} < padTarget)) begin
        next_cur.state = rmds_pkg::ST_PAD;
      end else if (lastCh && dl && flex && ({3'h0, next_cur.total} < fillTarget)) begin
        next_cur.state = rmds_pkg::ST_FILL;
      end else begin
        // uplink never pads and ends the frame on the last channel
        next_cur.state = rmds_pkg::ST_TAKE;
        if (lastCh) begin
          next_cur.frameDone = 1'b1;
          next_cur.lastTotal = next_cur.total;
          next_cur.total     = 16'h0000;
          next_cur.physCnt   = 16'h0000;
          next_cur.physIdx   = 3'h0;
          next_cur.firstPend = 1'b1;
        end
      end
    end

    // a one-cycle gap after every take, also when the bit was punctured
    next_cur.inReady = (next_cur.state == rmds_pkg::ST_TAKE) && !next_cur.outValid &&
                       !take && next_cur.ctrl[`RMDS_CTRL_EN];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cur           <= '0;
      cur.ctrl      <= `RMDS_CTRL_RST;
      cur.phyLen    <= `RMDS_PHYLEN_RST;
      cur.firstPend <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign regRdata  = cur.rdata;
  assign inReady   = cur.inReady;
  assign outValid  = cur.outValid;
  assign outBit    = cur.outBit;
  assign outDtx    = cur.outDtx;
  assign outFirst  = cur.outFirst;
  assign outPhys   = cur.outPhys;
  assign frameDone = cur.frameDone;
endmodule : rmds_top

// ### design/rmds_map.svh
// Purpose: address map, field positions and reset values of the rate match chain
// Assumes: 16-bit register port, word addressed, 7-bit address
// Notes:   per-channel registers sit at 0x40 + 16*channel + field
// Overview of operation
// - turbo uplink: split S/P1/P2, never puncture S
// - uplink order S,P1,P2 or S,P2,P1 by interval
// - uplink frame start type from interval, frame index
// - downlink turbo order always S,P1,P2
// - puncture: subtract decrement, drop at <=0, add increment
// - repeat: copy bit while accumulator <=0
// - repeated copy follows its original immediately
// - output count equals input plus signed adjustment
// - each frame period combine all channel frames
// - channels output serially in channel order
// - fixed or flexible insertion chosen per composite
// - marks are flagged, never sent as data
// - fixed: pad channel to frames times reserved size
// - each element is zero, one or mark
// - flexible: pad composite to physical channels times length
// - split frame into equal consecutive physical blocks
// - uplink: no marks, segment multiplexed stream directly
// - zero adjustment bypasses the rate engine
`ifndef RMDS_MAP_SVH
`define RMDS_MAP_SVH
`define RMDS_REG_CTRL     7'h00
`define RMDS_REG_PHYLEN   7'h01
`define RMDS_REG_STATUS   7'h02
`define RMDS_REG_CHCOUNT  7'h03
`define RMDS_REG_TOTAL    7'h04
`define RMDS_CH_SPACE     6
`define RMDS_F_CFG        4'h0
`define RMDS_F_ADJ        4'h1
`define RMDS_F_EINI1      4'h2
`define RMDS_F_EPLUS1     4'h3
`define RMDS_F_EMINUS1    4'h4
`define RMDS_F_EINI2      4'h5
`define RMDS_F_EPLUS2     4'h6
`define RMDS_F_EMINUS2    4'h7
`define RMDS_F_RES        4'h8
`define RMDS_CTRL_EN      0
`define RMDS_CTRL_DL      1
`define RMDS_CTRL_FLEX    2
`define RMDS_CTRL_NCH_LO  3
`define RMDS_CTRL_NPH_LO  5
`define RMDS_CFG_TTI_LO   0
`define RMDS_CFG_FIDX_LO  2
`define RMDS_CFG_TURBO    5
`define RMDS_CTRL_RST     16'h0000
`define RMDS_PHYLEN_RST   16'h0000
`endif

// ### design/rmds_pkg.sv
// Purpose: types shared by the rate match chain modules
// Assumes: four transport channels, up to eight physical channels
// Notes:   all module state is held in the packed structs below
package rmds_pkg;
  typedef enum logic [1:0] {BIT_SYS, BIT_PAR1, BIT_PAR2} rmds_bit_t;
  typedef enum logic [1:0] {ST_TAKE, ST_REP, ST_PAD, ST_FILL} rmds_state_t;
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] adj;
    logic [15:0] eIni1;
    logic [15:0] ePlus1;
    logic [15:0] eMinus1;
    logic [15:0] eIni2;
    logic [15:0] ePlus2;
    logic [15:0] eMinus2;
    logic [15:0] res;
  } rmds_chan_t;
  typedef struct packed {
    logic signed [17:0] err;
  } rmds_eng_t;
  typedef struct packed {
    rmds_chan_t [3:0] ch;
    logic [15:0]      ctrl;
    logic [15:0]      phyLen;
    logic [15:0]      rdata;
    logic [15:0]      chanCnt;
    logic [15:0]      total;
    logic [15:0]      lastTotal;
    logic [15:0]      physCnt;
    logic [2:0]       physIdx;
    logic [2:0]       outPhys;
    logic [1:0]       chan;
    rmds_state_t      state;
    rmds_bit_t        nextType;
    logic             curBit;
    logic             lastIn;
    logic             firstPend;
    logic             inReady;
    logic             outValid;
    logic             outBit;
    logic             outDtx;
    logic             outFirst;
    logic             frameDone;
  } rmds_top_t;
endpackage : rmds_pkg

// ### design/rmds_rm_if.sv
// Purpose: control and result signals between the chain and one rate engine
// Assumes: single clock domain
// Notes:   hit flags are combinational from the engine
`timescale 1ns/1ns
interface rmds_rm_if;
  logic        load;
  logic        take;
  logic        again;
  logic        puncture;
  logic [15:0] eIni;
  logic [15:0] ePlus;
  logic [15:0] eMinus;
  logic        hitTake;
  logic        hitAgain;
  modport ctrl (output load, take, again, puncture, eIni, ePlus, eMinus,
                input hitTake, hitAgain);
  modport eng  (input load, take, again, puncture, eIni, ePlus, eMinus,
                output hitTake, hitAgain);
endinterface : rmds_rm_if

// ### design/rmds_rate_engine.sv
// Purpose: error accumulator deciding puncture or repetition of each bit
// Assumes: load may coincide with take, then the initial value is used
// Notes:   hitTake tells the caller to drop (puncture) or copy (repeat)
`timescale 1ns/1ns
module rmds_rate_engine (
  input wire logic core_clk,
  input wire logic rst_b,
  rmds_rm_if.eng   rm
);
  rmds_pkg::rmds_eng_t cur;
  rmds_pkg::rmds_eng_t next_cur;
  logic signed [17:0]  base;
  logic signed [17:0]  afterMinus;
  logic signed [17:0]  afterPlus;
  logic signed [17:0]  plusVal;

  always_comb begin
    plusVal     = $signed({2'b00, rm.ePlus});
    base        = rm.load ? $signed({2'b00, rm.eIni}) : cur.err;
    afterMinus  = base - $signed({2'b00, rm.eMinus});
    afterPlus   = cur.err + plusVal;
    rm.hitTake  = (afterMinus <= 18'sd0);
    rm.hitAgain = (afterPlus <= 18'sd0);
    next_cur    = cur;
    if (rm.take) begin
      if (rm.puncture && rm.hitTake) begin
        next_cur.err = afterMinus + plusVal;
      end else begin
        next_cur.err = afterMinus;
      end
    end else if (rm.again) begin
      next_cur.err = afterPlus;
    end else if (rm.load) begin
      next_cur.err = $signed({2'b00, rm.eIni});
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule : rmds_rate_engine

// ### verification/rmds_monitor.sv
// Purpose: port-level checks of the rate match chain handshakes
// Assumes: single clock, synchronous active-low reset
// Notes:   bound to rmds_top below
`timescale 1ns/1ns
module rmds_monitor (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        regRd,
  input wire logic [15:0] regRdata,
  input wire logic        inValid,
  input wire logic        inReady,
  input wire logic        outValid,
  input wire logic        outReady,
  input wire logic        outBit,
  input wire logic        outDtx,
  input wire logic        outFirst,
  input wire logic [2:0]  outPhys,
  input wire logic        frameDone
);
  default clocking mcb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence inTake;
    inValid && inReady;
  endsequence
  sequence outStall;
    outValid && !outReady;
  endsequence
  sequence firstTake;
    outValid && outReady && outFirst;
  endsequence
  take_drop_ready_a: assert property (inTake |=> !inReady)
    else $error("input ready stayed high after a take");
  out_full_refuse_a: assert property (inTake |-> !outStall)
    else $error("input taken while output element stalled");
  out_hold_a: assert property (outStall |=> outValid &&
      $stable({outBit, outDtx, outFirst, outPhys}))
    else $error("stalled output element changed");
  mark_zero_a: assert property (outValid && outDtx |-> !outBit)
    else $error("mark element carries a one");
  first_once_a: assert property (firstTake |=> !(outValid && outFirst) [*3])
    else $error("frame start flag repeated");
  done_pulse_a: assert property (frameDone |=> !frameDone)
    else $error("frame done longer than one cycle");
  rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 16'h0000)
    else $error("read data outside read answer cycle");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_b |=>
      !outValid && !inReady && !frameDone && regRdata == 16'h0000)
    else $error("outputs active after reset");
endmodule : rmds_monitor
bind rmds_top rmds_monitor u_monitor (.core_clk, .rst_b, .regRd, .regRdata, .inValid,
  .inReady, .outValid, .outReady, .outBit, .outDtx, .outFirst, .outPhys, .frameDone);

// ### verification/rmds_sink_model.sv
// Purpose: downstream interleaver stand-in collecting output elements
// Assumes: element taken on an edge with valid and ready high
// Notes:   stall lets one cycle in four accept
`timescale 1ns/1ns
module rmds_sink_model (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       stall,
  input  wire logic       outValid,
  output logic            outReady,
  input  wire logic       outBit,
  input  wire logic       outDtx,
  input  wire logic       outFirst,
  input  wire logic [2:0] outPhys,
  input  wire logic       frameDone
);
  logic [5:0] got[$];
  int         frames = 0;
  logic [1:0] phase = 2'h0;
  always @(posedge core_clk) begin
    phase <= phase + 2'h1;
    outReady <= rst_b && (!stall || phase == 2'h2);
    if (rst_b && outValid && outReady) begin
      got.push_back({outFirst, outPhys, outDtx, outBit});
    end
    if (rst_b && frameDone) begin
      frames <= frames + 1;
    end
  end
endmodule : rmds_sink_model

// ### verification/rate_match_mux_dtx_segmenter_tb.sv
// Purpose: self-checking bench for rmds_top
// Assumes: bench acts as encoder, sink model as interleaver
// Notes:   expected streams rebuilt from channel setup
`timescale 1ns/1ns
module rate_match_mux_dtx_segmenter_tb;
  logic        core_clk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [6:0]  regAddr = 7'h00;
  logic [15:0] regWdata = 16'h0000, regRdata;
  logic        inValid = 1'b0, inBit = 1'b0, inFirst = 1'b0, inLast = 1'b0;
  logic [1:0]  inChan = 2'h0;
  logic        inReady, outValid, outReady, outBit, outDtx, outFirst, frameDone;
  logic [2:0]  outPhys;
  logic        stall = 1'b0;
  logic [5:0]  exp[$];
  int          cr [4][9];
  int          tt [4] = '{0, 5, 10, 23};
  int          bad_count = 0, samples_checked = 0, dl, flex, nPh, phLen, seen = 0;
  always #20 core_clk = ~core_clk;
  rmds_top dut (.core_clk, .rst_b, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .inValid, .inReady, .inBit, .inFirst, .inLast, .inChan, .outValid, .outReady,
    .outBit, .outDtx, .outFirst, .outPhys, .frameDone);
  rmds_sink_model sink (.core_clk, .rst_b, .stall, .outValid, .outReady, .outBit,
    .outDtx, .outFirst, .outPhys, .frameDone);
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
    samples_checked++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h want %h", $time, what, got, want);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [15:0] want);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, want, "register read");
  endtask : rd
  task automatic cfg(input int ch, input int v [9]);
    for (int f = 0; f < 9; f++) begin
      cr[ch][f] = v[f];
      wr(7'(64 + ch * 16 + f), 16'(v[f]));
    end
  endtask : cfg
  task automatic setup(input int down, input int fx, input int lastCh, input int p, input int u);
    dl = down;
    flex = fx;
    nPh = p;
    phLen = u;
    wr(7'h01, 16'(u));
    wr(7'h00, 16'(1 + 2 * down + 4 * fx + 8 * lastCh + 32 * (p - 1)));
    exp.delete();
    sink.got.delete();
  endtask : setup
  function automatic void push(input logic b, input logic d);
    int k = exp.size();
    logic [2:0] ph = (phLen == 0) ? 3'h0 : 3'((k / phLen) % nPh);
    exp.push_back({k == 0, ph, d, b & ~d});
  endfunction : push
  task automatic drive(input int ch, input logic b, input logic f, input logic l);
    @(posedge core_clk);
    inValid <= 1'b1;
    inBit <= b;
    inFirst <= f;
    inLast <= l;
    inChan <= 2'(ch);
    repeat (40) begin
      @(posedge core_clk);
      if (inReady) break;
    end
    inValid <= 1'b0;
    inBit <= ~b;
  endtask : drive
  task automatic send_ch(input int ch, input int n, input logic [15:0] pat);
    int c, t, e1, e2, e, sel, cnt, adj;
    c = cr[ch][0];
    adj = cr[ch][1];
    e1 = cr[ch][2];
    e2 = cr[ch][5];
    cnt = 0;
    t = dl ? 0 : c[1:0] == 1 ? c[4:2] : c[1:0] == 2 ? (3 - c[4:2]) % 3 : c[4:2] % 3;
    for (int k = 0; k < n; k++) begin
      drive(ch, pat[k], k == 0, k == n - 1);
      if (adj == 0 || (adj < 0 && c[5] && t == 0)) begin
        push(pat[k], 1'b0);
        cnt++;
      end else begin
        sel = (adj < 0 && c[5] && t == 2) ? 3 : 0;
        e = (sel == 3 ? e2 : e1) - cr[ch][4 + sel];
        if (adj < 0 && e <= 0) e += cr[ch][3 + sel];
        else begin
          push(pat[k], 1'b0);
          cnt++;
        end
        while (adj > 0 && e <= 0) begin
          push(pat[k], 1'b0);
          cnt++;
          e += cr[ch][3];
        end
        if (sel == 3) e2 = e;
        else e1 = e;
      end
      t = (!dl && c[0]) ? (t + 2) % 3 : (t + 1) % 3;
    end
    while (dl && !flex && cnt < (cr[ch][8] << c[1:0])) begin
      push(1'b0, 1'b1);
      cnt++;
    end
  endtask : send_ch
  task automatic end_frame(input string what);
    while (flex && exp.size() < nPh * phLen) push(1'b0, 1'b1);
    for (int w = 0; w < 600 && sink.frames == seen; w++) @(posedge core_clk);
    seen++;
    repeat (8) @(posedge core_clk);
    chk(16'(sink.frames), 16'(seen), what);
    chk(16'(sink.got.size()), 16'(exp.size()), what);
    foreach (exp[i]) chk(16'(sink.got[i]), 16'(exp[i]), what);
  endtask : end_frame
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(7'h00, 16'h0000);
    rd(7'h01, 16'h0000);
    rd(7'h02, 16'h0000);
    wr(7'h30, 16'hFFFF);
    rd(7'h30, 16'h0000);
    wr(7'h40, 16'h0023);
    rd(7'h40, 16'h0023);
    stall <= 1'b1;
    cfg(0, '{0, 0, 0, 0, 0, 0, 0, 0, 4});
    cfg(1, '{0, -2, 6, 12, 4, 0, 0, 0, 4});
    setup(0, 0, 1, 2, 4);
    send_ch(0, 4, 16'h000B);
    send_ch(1, 6, 16'h002D);
    end_frame("uplink mux");
    rd(7'h03, 16'h0004);
    rd(7'h04, 16'h0008);
    cfg(0, '{0, 2, 4, 8, 4, 0, 0, 0, 0});
    setup(0, 0, 0, 1, 0);
    send_ch(0, 4, 16'h0005);
    end_frame("repeat");
    rd(7'h04, 16'h0006);
    stall <= 1'b0;
    foreach (tt[i]) begin
      cfg(0, '{32 + tt[i], -3, 2, 4, 2, 1, 2, 1, 0});
      setup(0, 0, 0, 1, 0);
      send_ch(0, 9, 16'h0135);
      end_frame("turbo uplink");
    end
    cfg(0, '{1, 0, 0, 0, 0, 0, 0, 0, 2});
    cfg(1, '{44, -2, 2, 4, 2, 1, 2, 1, 5});
    setup(1, 0, 1, 1, 0);
    send_ch(0, 3, 16'h0005);
    send_ch(1, 6, 16'h0036);
    end_frame("fixed marks");
    stall <= 1'b1;
    cfg(0, '{0, 0, 0, 0, 0, 0, 0, 0, 0});
    cfg(1, '{0, 0, 0, 0, 0, 0, 0, 0, 0});
    setup(1, 1, 1, 2, 6);
    send_ch(0, 2, 16'h0002);
    send_ch(1, 3, 16'h0006);
    end_frame("flexible marks");
    rd(7'h04, 16'h000C);
    final_report();
  end
endmodule : rate_match_mux_dtx_segmenter_tb
